// File: verilog/ufc_pkg.sv
// constants, carrier types and register map of the serial transceiver
// What this block does
// - rx_polarity_invert set means the receive line idles low, else high.
// - high_speed_baud_select gives 4 baud ticks per bit, else 16.
// - parity_data_select: 11 nine bits, 10 odd, 01 even, 00 eight plain.
// - stop_count_select sends two stop bits when set, one when clear.
// - four-entry transmit queue, characters sent in write order.
// - four-entry receive queue, read out in arrival order.
// - parity, framing and overrun errors raise their own interrupt.
// - nine-bit address detect keeps only characters whose ninth bit is one.
// - 16-bit programmable divisor derives the baud tick from the clock.
// - optional clear-to-send input and request-to-send output flow control.
// - transmit and receive events also pulse a DMA request.
// - loopback feeds the transmitter output back into the receiver.
// - transmitter sends break and sync characters on request.
// - auto-baud measures an incoming start bit to set the divisor.
// - infrared encode/decode on the lines plus a baud tick output, 16x the bit rate (4x with high_speed_baud_select).
package ufc_pkg;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned PTR_W      = 2;
    localparam int unsigned CNT_W      = 3;
    localparam int unsigned IRQ_W      = 6;

    localparam logic [7:0] A_MODE   = 8'h00;
    localparam logic [7:0] A_BAUD   = 8'h04;
    localparam logic [7:0] A_CTRL   = 8'h08;
    localparam logic [7:0] A_TXDATA = 8'h0C;
    localparam logic [7:0] A_RXDATA = 8'h10;
    localparam logic [7:0] A_STAT   = 8'h14;
    localparam logic [7:0] A_IRQ    = 8'h18;
    localparam logic [7:0] A_MASK   = 8'h1C;

    localparam int unsigned CB_BREAK = 4;
    localparam int unsigned CB_SYNC  = 5;

    localparam int unsigned IB_TX  = 0;
    localparam int unsigned IB_RX  = 1;
    localparam int unsigned IB_PAR = 2;
    localparam int unsigned IB_FRM = 3;
    localparam int unsigned IB_OVR = 4;
    localparam int unsigned IB_ABD = 5;
    localparam logic [IRQ_W-1:0] ERR_BITS = 6'h1C;

    localparam logic [1:0] PDS_9N = 2'h3;
    localparam logic [1:0] PDS_8O = 2'h2;
    localparam logic [1:0] PDS_8E = 2'h1;
    localparam logic [1:0] PDS_8N = 2'h0;

    localparam logic [4:0]  OVS_STD     = 5'h10;
    localparam logic [4:0]  OVS_HS      = 5'h04;
    localparam logic [4:0]  IR_W_STD    = 5'h03;
    localparam logic [4:0]  IR_W_HS     = 5'h01;
    localparam logic [3:0]  BRK_BITS    = 4'hD;
    localparam logic [8:0]  SYNC_CHAR   = 9'h055;
    localparam logic [15:0] MODE_RST    = 16'h0000;
    localparam logic [15:0] BAUD_RST    = 16'h0000;

    typedef struct packed {
        logic       enable;
        logic [4:0] rsv;
        logic       addr_detect;
        logic       flow_ctl;
        logic       ir_enable;
        logic       autobaud;
        logic       loopback;
        logic       rx_polarity_invert;
        logic       high_speed_baud_select;
        logic [1:0] parity_data_select;
        logic       stop_count_select;
    } ufc_mode_t;

    typedef struct packed {
        logic       ferr;
        logic       perr;
        logic [8:0] data;
    } ufc_rx_entry_t;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'h01,
        TX_START = 6'h02,
        TX_DATA  = 6'h04,
        TX_PAR   = 6'h08,
        TX_STOP  = 6'h10,
        TX_BRK   = 6'h20
    } ufc_tx_st_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } ufc_rx_st_t;

    typedef struct packed {
        ufc_mode_t                                mode;
        logic [15:0]                              baud;
        logic [1:0]                               tx_irq_select;
        logic [1:0]                               rx_irq_select;
        logic [IRQ_W-1:0]                         irq_st;
        logic [IRQ_W-1:0]                         mask;
        logic [15:0]                              brg_cnt;
        logic [FIFO_DEPTH-1:0][8:0]               txf;
        logic [PTR_W-1:0]                         txf_rd;
        logic [PTR_W-1:0]                         txf_wr;
        logic [CNT_W-1:0]                         txf_cnt;
        logic [FIFO_DEPTH-1:0][10:0]              rxf;
        logic [PTR_W-1:0]                         rxf_rd;
        logic [PTR_W-1:0]                         rxf_wr;
        logic [CNT_W-1:0]                         rxf_cnt;
        ufc_tx_st_t                               tx_st;
        logic [8:0]                               tx_sh;
        logic [4:0]                               tx_cnt;
        logic [3:0]                               tx_bit;
        logic [1:0]                               tx_stops;
        logic                                     break_req;
        logic                                     txl;
        ufc_rx_st_t                               rx_st;
        logic [8:0]                               rx_sh;
        logic [4:0]                               rx_cnt;
        logic [3:0]                               rx_bit;
        logic                                     rx_perr;
        logic [4:0]                               ir_hold;
        logic                                     ab_run;
        logic [19:0]                              ab_cnt;
        logic                                     rx_s1;
        logic                                     rx_s2;
        logic                                     cts_s1;
        logic                                     cts_s2;
        logic                                     pready;
        logic                                     pslverr;
        logic [31:0]                              prdata;
        logic                                     out;
        logic                                     rts;
        logic                                     b16;
        logic                                     irq;
        logic                                     err_irq;
        logic                                     dma_tx;
        logic                                     dma_rx;
    } ufc_state_t;

    localparam ufc_state_t ST_RST = '{
        mode: MODE_RST, baud: BAUD_RST, tx_st: TX_IDLE, rx_st: RX_IDLE,
        txl: 1'b1, out: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, default: '0};
endpackage

// File: verilog/ufc_uart.sv
// serial transceiver core: APB registers, baud generator, tx/rx engines
`timescale 1ns/1ps
`default_nettype none
module ufc_uart
    import ufc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in_pin,
    input  wire logic        clear_to_send_in,
    output logic             serial_out_pin,
    output logic             request_to_send_out,
    output logic             baud16_out,
    output logic             irq,
    output logic             err_irq,
    output logic             dma_tx_req,
    output logic             dma_rx_req
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] ovs(input logic hs);
        ovs = hs ? OVS_HS : OVS_STD;
    endfunction

    function automatic logic [3:0] nbits(input logic [1:0] pds);
        nbits = (pds == PDS_9N) ? 4'h9 : 4'h8;
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] pds);
        par_bit = (pds == PDS_8O) ? ~(^d) : (^d);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    ufc_state_t q;
    ufc_state_t n;

    logic             tick;
    logic             line;
    logic             raw;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             mapped;
    logic             tx_end;
    logic [4:0]       nov;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [19:0]      ab_div;
    ufc_rx_entry_t    ent;

    always_comb begin
        n       = q;
        tick    = 1'b0;
        ev      = '0;
        clr     = '0;
        ab_div  = '0;
        ent     = '0;
        tx_end  = 1'b0;
        nov     = ovs(q.mode.high_speed_baud_select);
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.dma_tx  = 1'b0;
        n.dma_rx  = 1'b0;
        n.b16     = 1'b0;

        // pin synchronisers
        n.rx_s1  = serial_in_pin;
        n.rx_s2  = q.rx_s1;
        n.cts_s1 = clear_to_send_in;
        n.cts_s2 = q.cts_s1;

        // baud tick: divisor+1 clocks per tick
        if (q.mode.enable) begin
            if (q.brg_cnt == 16'h0000) begin
                tick    = 1'b1;
                n.brg_cnt = q.baud;
                n.b16   = 1'b1;
            end else begin
                n.brg_cnt = q.brg_cnt - 16'h0001;
            end
        end else begin
            n.brg_cnt = q.baud;
        end

        // receive line selection
        raw = q.mode.loopback ? q.txl : q.rx_s2;
        if (q.mode.ir_enable && !q.mode.loopback) begin
            if (raw) begin
                n.ir_hold = nov;
            end else if (tick && q.ir_hold != 5'h00) begin
                n.ir_hold = q.ir_hold - 5'h01;
            end
            line = (q.ir_hold == 5'h00);
        end else begin
            n.ir_hold = '0;
            line = raw ^ q.mode.rx_polarity_invert;
        end

        // APB access phase
        acc    = psel && penable;
        mapped = (paddr[1:0] == 2'h0) && (paddr <= A_MASK);
        wr     = acc && q.pready && pwrite && mapped;
        rd     = acc && q.pready && !pwrite && mapped;
        if (acc && !q.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !mapped;
            case (paddr)
                A_MODE:   n.prdata = {16'h0000, q.mode};
                A_BAUD:   n.prdata = {16'h0000, q.baud};
                A_CTRL:   n.prdata = {28'h0000000, q.rx_irq_select, q.tx_irq_select};
                A_RXDATA: n.prdata = {21'h000000, q.rxf[q.rxf_rd]};
                A_STAT:   n.prdata = {23'h000000, q.ab_run, q.rx_st != RX_IDLE,
                                      q.tx_st != TX_IDLE, q.rxf_cnt, q.txf_cnt};
                A_IRQ:    n.prdata = {26'h0000000, q.irq_st};
                A_MASK:   n.prdata = {26'h0000000, q.mask};
                default:  n.prdata = 32'h00000000;
            endcase
        end

        // register writes
        if (wr) begin
            case (paddr)
                A_MODE: begin
                    n.mode     = ufc_mode_t'(pwdata[15:0]);
                    n.mode.rsv = '0;
                end
                A_BAUD: n.baud = pwdata[15:0];
                A_CTRL: begin
                    n.tx_irq_select = pwdata[1:0];
                    n.rx_irq_select = pwdata[3:2];
                    if (pwdata[CB_BREAK]) begin
                        n.break_req = 1'b1;
                    end
                end
                A_IRQ:  clr = pwdata[IRQ_W-1:0];
                A_MASK: n.mask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // receive queue pop on data read
        if (rd && paddr == A_RXDATA && q.rxf_cnt != '0) begin
            n.rxf_rd  = q.rxf_rd + PTR_W'(1);
            n.rxf_cnt = n.rxf_cnt - CNT_W'(1);
        end

        // transmitter
        if (tick && q.tx_st != TX_IDLE) begin
            if (q.tx_cnt == nov - 5'h01) begin
                n.tx_cnt = '0;
                tx_end   = 1'b1;
            end else begin
                n.tx_cnt = q.tx_cnt + 5'h01;
            end
        end
        case (q.tx_st)
            TX_IDLE: begin
                n.tx_cnt = '0;
                if (q.break_req && q.mode.enable) begin
                    n.break_req = 1'b0;
                    n.tx_bit    = '0;
                    n.tx_st     = TX_BRK;
                end else if (q.txf_cnt != '0 && q.mode.enable &&
                             (!q.mode.flow_ctl || q.cts_s2)) begin
                    n.tx_sh   = q.txf[q.txf_rd];
                    n.txf_rd  = q.txf_rd + PTR_W'(1);
                    n.txf_cnt = n.txf_cnt - CNT_W'(1);
                    n.tx_st   = TX_START;
                    if (q.tx_irq_select != 2'h1 &&
                        (q.tx_irq_select != 2'h2 || q.txf_cnt == CNT_W'(1))) begin
                        ev[IB_TX] = 1'b1;
                    end
                end
            end
            TX_START: begin
                if (tx_end) begin
                    n.tx_bit = '0;
                    n.tx_st  = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_end) begin
                    n.tx_bit = q.tx_bit + 4'h1;
                    if (q.tx_bit == nbits(q.mode.parity_data_select) - 4'h1) begin
                        n.tx_stops = q.mode.stop_count_select ? 2'h2 : 2'h1;
                        if (q.mode.parity_data_select == PDS_8O ||
                            q.mode.parity_data_select == PDS_8E) begin
                            n.tx_st = TX_PAR;
                        end else begin
                            n.tx_st = TX_STOP;
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    n.tx_st = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    n.tx_stops = q.tx_stops - 2'h1;
                    if (q.tx_stops == 2'h1) begin
                        n.tx_st = TX_IDLE;
                        if (q.tx_irq_select == 2'h1 && q.txf_cnt == '0) begin
                            ev[IB_TX] = 1'b1;
                        end
                    end
                end
            end
            TX_BRK: begin
                if (tx_end) begin
                    n.tx_bit = q.tx_bit + 4'h1;
                    if (q.tx_bit == BRK_BITS - 4'h1) begin
                        n.tx_stops = 2'h1;
                        n.tx_st    = TX_STOP;
                    end
                end
            end
            default: n.tx_st = TX_IDLE;
        endcase

        // transmit queue push: data word or sync character
        if (wr && (paddr == A_TXDATA || (paddr == A_CTRL && pwdata[CB_SYNC])) &&
            q.txf_cnt != CNT_W'(FIFO_DEPTH)) begin
            n.txf[q.txf_wr] = (paddr == A_TXDATA) ? pwdata[8:0] : SYNC_CHAR;
            n.txf_wr  = q.txf_wr + PTR_W'(1);
            n.txf_cnt = n.txf_cnt + CNT_W'(1);
        end

        // auto-baud: time the start bit in clocks
        if (q.mode.autobaud) begin
            if (!q.ab_run) begin
                n.ab_cnt = '0;
                n.ab_run = !line;
            end else if (!line) begin
                if (q.ab_cnt != 20'hFFFFF) begin
                    n.ab_cnt = q.ab_cnt + 20'h00001;
                end
            end else begin
                ab_div = q.ab_cnt >> (q.mode.high_speed_baud_select ? 2 : 4);
                n.baud = (ab_div[15:0] == 16'h0000) ? 16'h0000 : ab_div[15:0] - 16'h0001;
                n.mode.autobaud = 1'b0;
                n.ab_run = 1'b0;
                ev[IB_ABD] = 1'b1;
            end
        end else begin
            n.ab_run = 1'b0;
        end

        // receiver
        case (q.rx_st)
            RX_IDLE: begin
                n.rx_cnt = '0;
                if (!line && q.mode.enable && !q.mode.autobaud) begin
                    n.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (tick) begin
                    if (q.rx_cnt == (nov >> 1) - 5'h01) begin
                        n.rx_cnt = '0;
                        n.rx_bit = '0;
                        n.rx_sh  = '0;
                        n.rx_st  = line ? RX_IDLE : RX_DATA;
                    end else begin
                        n.rx_cnt = q.rx_cnt + 5'h01;
                    end
                end
            end
            RX_DATA, RX_PAR, RX_STOP: begin
                if (tick) begin
                    if (q.rx_cnt == nov - 5'h01) begin
                        n.rx_cnt = '0;
                        if (q.rx_st == RX_DATA) begin
                            n.rx_sh[q.rx_bit] = line;
                            n.rx_bit = q.rx_bit + 4'h1;
                            if (q.rx_bit == nbits(q.mode.parity_data_select) - 4'h1) begin
                                n.rx_st = (q.mode.parity_data_select == PDS_8O ||
                                           q.mode.parity_data_select == PDS_8E) ? RX_PAR : RX_STOP;
                            end
                        end else if (q.rx_st == RX_PAR) begin
                            n.rx_perr = line ^ par_bit(q.rx_sh[7:0], q.mode.parity_data_select);
                            n.rx_st   = RX_STOP;
                        end else begin
                            n.rx_st  = RX_IDLE;
                            ent.data = q.rx_sh;
                            ent.perr = q.rx_perr;
                            ent.ferr = !line;
                            n.rx_perr = 1'b0;
                            if (q.mode.addr_detect && q.mode.parity_data_select == PDS_9N &&
                                !q.rx_sh[8]) begin
                                ent = ent;
                            end else if (q.rxf_cnt == CNT_W'(FIFO_DEPTH)) begin
                                ev[IB_OVR] = 1'b1;
                            end else begin
                                ev[IB_PAR] = ent.perr;
                                ev[IB_FRM] = ent.ferr;
                                n.rxf[q.rxf_wr] = ent;
                                n.rxf_wr  = q.rxf_wr + PTR_W'(1);
                                n.rxf_cnt = n.rxf_cnt + CNT_W'(1);
                                case (q.rx_irq_select)
                                    2'h2:    ev[IB_RX] = (n.rxf_cnt == CNT_W'(FIFO_DEPTH - 1));
                                    2'h3:    ev[IB_RX] = (n.rxf_cnt == CNT_W'(FIFO_DEPTH));
                                    default: ev[IB_RX] = 1'b1;
                                endcase
                            end
                        end
                    end else begin
                        n.rx_cnt = q.rx_cnt + 5'h01;
                    end
                end
            end
            default: n.rx_st = RX_IDLE;
        endcase

        // transmit line level from next state
        case (n.tx_st)
            TX_START: n.txl = 1'b0;
            TX_DATA:  n.txl = n.tx_sh[n.tx_bit];
            TX_PAR:   n.txl = par_bit(n.tx_sh[7:0], n.mode.parity_data_select);
            TX_BRK:   n.txl = 1'b0;
            default:  n.txl = 1'b1;
        endcase
        // infrared: short high pulse marks a zero bit
        if (n.mode.ir_enable) begin
            n.out = !n.txl && (n.tx_cnt < (n.mode.high_speed_baud_select ? IR_W_HS : IR_W_STD));
        end else begin
            n.out = n.txl;
        end

        // sticky events, set wins over clear
        n.irq_st  = (q.irq_st & ~clr) | ev;
        n.irq     = |(n.irq_st & n.mask & ~ERR_BITS);
        n.err_irq = |(n.irq_st & n.mask & ERR_BITS);
        n.dma_tx  = ev[IB_TX];
        n.dma_rx  = ev[IB_RX];
        n.rts     = n.mode.flow_ctl && (n.rxf_cnt != CNT_W'(FIFO_DEPTH));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ST_RST;
        end else if (ce) begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign serial_out_pin      = q.out;
    assign request_to_send_out = q.rts;
    assign baud16_out          = q.b16;
    assign irq                 = q.irq;
    assign err_irq             = q.err_irq;
    assign dma_tx_req          = q.dma_tx;
    assign dma_rx_req          = q.dma_rx;
endmodule // ufc_uart
`default_nettype wire

// File: verification/ufc_monitor.sv
// port checker of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ufc_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_out_pin,
    input wire logic        dma_tx_req,
    input wire logic        dma_rx_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic bad_a = paddr > 8'h1C || paddr[1:0] != 2'h0;
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
    a_unmapped_err: assert property (pready && bad_a |-> pslverr && prdata == 32'h0) else $error("no slverr");
    a_mapped_ok: assert property (pready && !bad_a |-> !pslverr) else $error("bad slverr");
    a_dma_tx_pulse: assert property (dma_tx_req |=> !dma_tx_req) else $error("tx dma held");
    a_dma_rx_pulse: assert property (dma_rx_req |=> !dma_rx_req) else $error("rx dma held");
    a_reset_idle: assert property (!$past(presetn) |-> serial_out_pin) else $error("line busy");
endmodule // ufc_monitor
bind ufc_uart ufc_monitor ufc_monitor_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
`default_nettype wire

// File: verification/ufc_partner.sv
// serial partner: frame sender and catcher
`timescale 1ns/1ps
`default_nettype none
module ufc_partner (
    input  wire logic pclk,
    input  wire logic line_in,
    output wire logic line_out
);
    logic lvl = 1'b1;
    logic inv = 1'b0;
    assign line_out = lvl ^ inv;
    task automatic send(input logic [12:0] v, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            lvl <= v[i];
            repeat (bc) @(posedge pclk);
        end
    endtask
    task automatic get(output logic [8:0] d, input int n, input int bc);
        while (line_in !== 1'b0) @(posedge pclk);
        repeat (bc / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            repeat (bc) @(posedge pclk);
            d[i] = line_in;
        end
    endtask
endmodule // ufc_partner
`default_nettype wire

// File: verification/tb.sv
// transceiver bench
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ufc_pkg::*;
    logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, sin, sout, irq, err_irq, e;
    logic        cts = 1'b1, rts, b16;
    logic [7:0]  paddr, txv [3] = '{8'h41, 8'hC3, 8'h0F};
    logic [31:0] pwdata, prdata, r;
    logic [8:0]  d;
    int          failures, n_tests;
    ufc_uart ufc_uart_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(sin),
        .clear_to_send_in(cts), .serial_out_pin(sout), .request_to_send_out(rts), .baud16_out(b16), .irq(irq),
        .err_irq(err_irq), .dma_tx_req(), .dma_rx_req());
    ufc_partner ufc_partner_inst (.pclk(pclk), .line_in(sout), .line_out(sin));
    initial forever #25 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) $display("[FAIL] %s expected %h seen %h", nm, x, s);
        if (s !== x) failures++;
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h22, 32'h0);
        chk("unmapped", {e, r[30:0]}, 32'h80000000);
        apb(1'b0, A_MODE, 32'h0);
        chk("mode", r, {16'h0, MODE_RST});
        $display("register done");
        apb(1'b1, A_MODE, 32'h8000);
        fork
            for (int i = 0; i < 3; i++) apb(1'b1, A_TXDATA, {24'h0, txv[i]});
            for (int j = 0; j < 3; j++) begin
                ufc_partner_inst.get(d, 9, 16);
                chk("tx", {23'h0, d}, {24'h1, txv[j]});
            end
        join
        $display("tx done");
        ufc_partner_inst.send(13'h34A, 10, 16);
        ufc_partner_inst.send(13'h278, 10, 16);
        chk("masked", {31'h0, irq}, 32'h0);
        apb(1'b1, A_MASK, 32'h2);
        apb(1'b0, A_RXDATA, 32'h0);
        chk("rx1", {r[30:0], irq}, {31'hA5, 1'b1});
        apb(1'b1, A_IRQ, 32'h2);
        apb(1'b0, A_RXDATA, 32'h0);
        chk("rx2", {r[30:0], irq}, {31'h3C, 1'b0});
        $display("rx done");
        apb(1'b1, A_MASK, {26'h0, ERR_BITS});
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, A_MODE, k ? 32'h8002 : 32'h8004);
            ufc_partner_inst.send(13'h402, 11, 16);
            apb(1'b0, A_RXDATA, 32'h0);
            chk("parity", {r[30:0], err_irq}, k ? 32'h403 : 32'h2);
        end
        $display("parity done");
        apb(1'b1, A_MODE, 32'h001E);
        ufc_partner_inst.inv <= 1'b1;
        apb(1'b1, A_MODE, 32'h801E);
        ufc_partner_inst.send(13'h74A, 11, 4);
        apb(1'b0, A_RXDATA, 32'h0);
        chk("nine", r, 32'h1A5);
        $display("nine bit done");
        cts <= 1'b0;
        apb(1'b1, A_MODE, 32'h8120);
        apb(1'b1, A_CTRL, 32'h20);
        repeat (200) @(posedge pclk);
        apb(1'b0, A_STAT, 32'h0);
        chk("held", {r[30:0], rts}, 32'h3);
        cts <= 1'b1;
        repeat (200) @(posedge pclk);
        apb(1'b0, A_RXDATA, 32'h0);
        chk("loop", {r[30:0], b16}, 32'hAB);
        $display("loopback done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
